//--- core/adc_ctrl_cfg.svh
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define ADR_REF_WIN      20'hf0010
`define ADR_UPPER_LIMIT  20'hf0011
`define ADR_LOWER_LIMIT  20'hf0012
`define ADR_TRIG_MODE    20'hfff32
`define ADR_RESULT_LO    20'hfff1e
`define ADR_RESULT_HI    20'hfff1f

`define RST_REF_WIN      8'h00
`define RST_TRIG_MODE    8'h00
`define RST_UPPER_LIMIT  8'hff
`define RST_LOWER_LIMIT  8'h00
`define RST_RESULT       16'h0000

`define TM_MODE_HI       7
`define TM_MODE_LO       6
`define TM_REPEAT        5
`define TM_SRC_HI        1
`define TM_SRC_LO        0
`define TM_WMASK         8'he3

`define RW_POS_HI        7
`define RW_POS_LO        6
`define RW_NEG           5
`define RW_INVERT        3
`define RW_WAKE          2
`define RW_RES8          0
`define RW_WMASK         8'hed

`define TRIG_BLANK_CYC   3'd4

`endif

//--- core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } conv_state_e;
    typedef enum logic [1:0] {
        TRG_TIMER = 2'b00,
        TRG_EVENT = 2'b01,
        TRG_RTC   = 2'b10,
        TRG_ITV   = 2'b11
    } hw_src_e;
    typedef logic [9:0] result_t;
endpackage

//--- core/adc_trigger_window_result_ctrl.sv
`timescale 1ns/1ns
`include "adc_ctrl_cfg.svh"
// Contract
// - repeat bit 0 runs sequential conversion in software trigger mode only, 1 runs one-shot.
// - source field picks timer, event link, rtc or interval timer trigger.
// - repeat rtc or interval trigger within three clocks ignored outside wake state.
// - plus reference: supply, external pin, internal 1.45 V; 11 prohibited.
// - minus reference is ground at 0, external pin at 1.
// - normal window: irq only when lower <= result <= upper.
// - inverted window: irq only when result below lower or above upper.
// - suppressed conversion leaves both result registers unchanged.
// - wake bit set: trigger in stop wakes and converts without cpu.
// - resolution bit 0 gives 10 bits, 1 gives 8 bits.
// - 16-bit result word from approximation register, low six bits zero.
// - upper eight bits at high byte, lower two at top of low byte.
// - 8-bit resolution returns zero in word bits 7 and 6.
// - read-only result byte holds upper eight result bits.
// - mode 00/01 software, 10 hardware no-wait, 11 hardware wait trigger.
module adc_trigger_window_result_ctrl (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        conversion_run_in,
    input  wire logic        comparator_power_on_in,
    input  wire logic        sw_start_in,
    input  wire logic        stop_mode_in,
    input  wire logic        timer_ch1_irq_in,
    input  wire logic        event_link_unit_in,
    input  wire logic        rtc_irq_in,
    input  wire logic        interval_timer_irq_in,
    input  wire logic        conv_end_in,
    input  wire logic [9:0]  approximation_reg_in,
    output logic      [7:0]  rdata_out,
    output logic             conv_start_out,
    output logic             power_wait_out,
    output logic             stop_wake_convert_out,
    output logic             resolution_8bit_out,
    output logic      [1:0]  pos_ref_sel_out,
    output logic             neg_ref_ext_out,
    output logic             conversion_done_irq_out
);
    logic [7:0]  trig_mode_r, trig_mode_nxt;
    logic [7:0]  ref_win_r, ref_win_nxt;
    logic [7:0]  upper_r, upper_nxt;
    logic [7:0]  lower_r, lower_nxt;
    logic [2:0]  blank_r, blank_nxt;
    logic        stop_wake_convert_r, stop_wake_convert_nxt;
    adc_ctrl_pkg::conv_state_e st_r, st_nxt;
    logic        start_r, start_nxt;
    logic        wait_r, wait_nxt;
    logic        irq_r, irq_nxt;
    logic        pref_hi_r, pref_lo_r, nref_r, res8_r;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        hw_sel, hw_mode, hw_wait, one_shot, hw_trig, fire;
    logic        in_window, pass, store;
    logic [15:0] word;
    logic [7:0]  byte_val;
    logic [7:0]  cmp;

    assign one_shot = trig_mode_r[`TM_REPEAT];
    assign hw_mode  = trig_mode_r[`TM_MODE_HI];
    assign hw_wait  = trig_mode_r[`TM_MODE_HI] & trig_mode_r[`TM_MODE_LO];

    always_comb begin
        case (adc_ctrl_pkg::hw_src_e'(trig_mode_r[`TM_SRC_HI:`TM_SRC_LO]))
            adc_ctrl_pkg::TRG_TIMER: hw_sel = timer_ch1_irq_in;
            adc_ctrl_pkg::TRG_EVENT: hw_sel = event_link_unit_in;
            adc_ctrl_pkg::TRG_RTC:   hw_sel = rtc_irq_in;
            adc_ctrl_pkg::TRG_ITV:   hw_sel = interval_timer_irq_in;
            default:                 hw_sel = 1'b0;
        endcase
    end

    // rtc and interval triggers blanked after the first
    assign hw_trig = hw_mode & hw_sel &
                     ((blank_r == 3'd0) | stop_wake_convert_r | ~trig_mode_r[`TM_SRC_HI]);

    always_comb begin
        blank_nxt = (blank_r != 3'd0) ? blank_r - 3'd1 : 3'd0;
        if (hw_trig && trig_mode_r[`TM_SRC_HI] && !stop_wake_convert_r) begin
            blank_nxt = `TRIG_BLANK_CYC - 3'd1;
        end
    end

    // wake bit plus stop: leave stop and convert without cpu
    assign stop_wake_convert_nxt = ref_win_r[`RW_WAKE] & stop_mode_in;

    assign fire = hw_mode ? hw_trig : sw_start_in;

    always_comb begin
        st_nxt    = st_r;
        start_nxt = 1'b0;
        wait_nxt  = 1'b0;
        case (st_r)
            adc_ctrl_pkg::ST_IDLE: begin
                if (fire && ((conversion_run_in && comparator_power_on_in) || stop_wake_convert_r)) begin
                    start_nxt = 1'b1;
                    wait_nxt  = hw_wait;
                    st_nxt    = adc_ctrl_pkg::ST_CONV;
                end
            end
            adc_ctrl_pkg::ST_CONV: begin
                if (conv_end_in) begin
                    st_nxt = adc_ctrl_pkg::ST_DONE;
                end
            end
            adc_ctrl_pkg::ST_DONE: begin
                if (!one_shot && conversion_run_in && !hw_mode) begin
                    start_nxt = 1'b1;
                    st_nxt    = adc_ctrl_pkg::ST_CONV;
                end else begin
                    st_nxt = adc_ctrl_pkg::ST_IDLE;
                end
            end
            default: st_nxt = adc_ctrl_pkg::ST_IDLE;
        endcase
    end

    // window compare on upper eight bits
    assign cmp       = approximation_reg_in[9:2];
    assign in_window = (lower_r <= cmp) && (cmp <= upper_r);
    assign pass      = ref_win_r[`RW_INVERT] ? ~in_window : in_window;
    assign store     = conv_end_in & (st_r == adc_ctrl_pkg::ST_CONV) & pass;
    assign irq_nxt   = store;

    always_comb begin
        trig_mode_nxt = trig_mode_r;
        ref_win_nxt   = ref_win_r;
        upper_nxt     = upper_r;
        lower_nxt     = lower_r;
        if (wr_in) begin
            case (addr_in)
                `ADR_TRIG_MODE:   trig_mode_nxt = wdata_in & `TM_WMASK;
                `ADR_REF_WIN:     ref_win_nxt   = wdata_in & `RW_WMASK;
                `ADR_UPPER_LIMIT: upper_nxt     = wdata_in;
                `ADR_LOWER_LIMIT: lower_nxt     = wdata_in;
                default:          trig_mode_nxt = trig_mode_r;
            endcase
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_in) begin
            case (addr_in)
                `ADR_TRIG_MODE:   rdata_nxt = trig_mode_r;
                `ADR_REF_WIN:     rdata_nxt = ref_win_r;
                `ADR_UPPER_LIMIT: rdata_nxt = upper_r;
                `ADR_LOWER_LIMIT: rdata_nxt = lower_r;
                `ADR_RESULT_LO:   rdata_nxt = word[7:0];
                `ADR_RESULT_HI:   rdata_nxt = byte_val;
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    result_store u_store (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .load_in     (store),
        .res8_in     (ref_win_r[`RW_RES8]),
        .value_in    (approximation_reg_in),
        .word_out    (word),
        .byte_out    (byte_val)
    );

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            trig_mode_r <= `RST_TRIG_MODE;
            ref_win_r   <= `RST_REF_WIN;
            upper_r     <= `RST_UPPER_LIMIT;
            lower_r     <= `RST_LOWER_LIMIT;
            blank_r     <= 3'd0;
            stop_wake_convert_r    <= 1'b0;
            st_r        <= adc_ctrl_pkg::ST_IDLE;
            start_r     <= 1'b0;
            wait_r      <= 1'b0;
            irq_r       <= 1'b0;
            rdata_r     <= 8'h00;
            pref_hi_r   <= 1'b0;
            pref_lo_r   <= 1'b0;
            nref_r      <= 1'b0;
            res8_r      <= 1'b0;
        end else begin
            trig_mode_r <= trig_mode_nxt;
            ref_win_r   <= ref_win_nxt;
            upper_r     <= upper_nxt;
            lower_r     <= lower_nxt;
            blank_r     <= blank_nxt;
            stop_wake_convert_r    <= stop_wake_convert_nxt;
            st_r        <= st_nxt;
            start_r     <= start_nxt;
            wait_r      <= wait_nxt;
            irq_r       <= irq_nxt;
            rdata_r     <= rdata_nxt;
            pref_hi_r   <= ref_win_nxt[`RW_POS_HI];
            pref_lo_r   <= ref_win_nxt[`RW_POS_LO];
            nref_r      <= ref_win_nxt[`RW_NEG];
            res8_r      <= ref_win_nxt[`RW_RES8];
        end
    end

    assign rdata_out               = rdata_r;
    assign conv_start_out          = start_r;
    assign power_wait_out          = wait_r;
    assign stop_wake_convert_out   = stop_wake_convert_r;
    assign resolution_8bit_out     = res8_r;
    assign pos_ref_sel_out         = {pref_hi_r, pref_lo_r};
    assign neg_ref_ext_out         = nref_r;
    assign conversion_done_irq_out = irq_r;

    a_irq_window_pass: assert property (@(posedge core_clk_in) disable iff (rst_in)
        store |=> conversion_done_irq_out) else $error("irq missing on pass");
    a_irq_only_pass: assert property (@(posedge core_clk_in) disable iff (rst_in)
        conversion_done_irq_out |-> $past(pass) && $past(conv_end_in))
        else $error("irq without passing end");
    a_hold_on_fail: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !store |=> $stable(word)) else $error("result changed on suppress");
    a_word_low_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
        word[5:0] == 6'h00) else $error("low bits nonzero");
    a_byte_is_top: assert property (@(posedge core_clk_in) disable iff (rst_in)
        byte_val == word[15:8]) else $error("byte mismatch");
    a_res8_zero_bits: assert property (@(posedge core_clk_in) disable iff (rst_in)
        store && ref_win_r[`RW_RES8] |=> word[7:6] == 2'h0)
        else $error("8-bit low bits set");
    a_irq_one_cycle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        conversion_done_irq_out |=> !conversion_done_irq_out) else $error("irq too long");
    a_blank_rtc: assert property (@(posedge core_clk_in) disable iff (rst_in)
        hw_trig && trig_mode_r[`TM_SRC_HI] && !stop_wake_convert_r |=> !hw_trig [*3])
        else $error("rtc retrigger accepted");
    a_one_shot_stop: assert property (@(posedge core_clk_in) disable iff (rst_in)
        st_r == adc_ctrl_pkg::ST_DONE && one_shot |=> st_r == adc_ctrl_pkg::ST_IDLE)
        else $error("one-shot repeated");
    a_sw_no_hw: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !hw_mode |-> !hw_trig) else $error("hw trigger in sw mode");
    a_ref_follows: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ##1 pos_ref_sel_out == ref_win_r[7:6]) else $error("ref select stale");
    a_wake_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ref_win_r[`RW_WAKE] && stop_mode_in |=> stop_wake_convert_out)
        else $error("no wake convert");

    c_pass_irq: cover property (@(posedge core_clk_in) conversion_done_irq_out);
    c_suppress: cover property (@(posedge core_clk_in) conv_end_in && !pass);
    c_wake: cover property (@(posedge core_clk_in) stop_wake_convert_out && conv_start_out);
endmodule

//--- core/result_store.sv
`timescale 1ns/1ns
`include "adc_ctrl_cfg.svh"
// result word and byte holder, loaded only on passing conversions
module result_store (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        load_in,
    input  wire logic        res8_in,
    input  wire logic [9:0]  value_in,
    output logic      [15:0] word_out,
    output logic      [7:0]  byte_out
);
    logic [15:0] word_r;
    logic [15:0] word_nxt;

    always_comb begin
        word_nxt = word_r;
        if (load_in) begin
            word_nxt = {value_in, 6'h00};
            if (res8_in) begin
                word_nxt[7:6] = 2'h0;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            word_r <= `RST_RESULT;
        end else begin
            word_r <= word_nxt;
        end
    end

    assign word_out = word_r;
    assign byte_out = word_r[15:8];
endmodule

//--- test/adc_core_model.sv
`timescale 1ns/1ns
// analog core stand-in: ends each conversion after a chosen delay
module adc_core_model (
    input  wire logic       core_clk_in,
    input  wire logic       start_in,
    input  wire logic [3:0] delay_in,
    input  wire logic [9:0] value_in,
    output logic            end_out,
    output logic      [9:0] approx_out
);
    int         cnt  = 0;
    logic [9:0] last = 10'h000;
    initial begin
        end_out    = 1'b0;
        approx_out = 10'h3ff;
    end
    // value only valid with the end pulse, inverted otherwise
    always @(posedge core_clk_in) begin
        end_out    <= 1'b0;
        approx_out <= ~last;
        if (cnt == 1) begin
            end_out    <= 1'b1;
            approx_out <= value_in;
            last       <= value_in;
        end
        if (cnt > 0)
            cnt <= cnt - 1;
        if (start_in === 1'b1)
            cnt <= int'(delay_in) + 1;
    end
endmodule

//--- test/tb_adc_trigger_window_result_ctrl.sv
`timescale 1ns/1ns
`include "adc_ctrl_cfg.svh"
module tb_adc_trigger_window_result_ctrl;
    logic        core_clk_in = 1'b0;
    logic        rst_in = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, pwr = 1'b0;
    logic        sw_start = 1'b0, stop = 1'b0, conv_end, start, pwait, wake, res8;
    logic        neg_ref, irq;
    logic [3:0]  trg = 4'h0, delay = 4'h0;
    logic [19:0] addr = 20'h00000;
    logic [7:0]  wdata = 8'h00, rdata, lo, up, exp_hi = 8'h00, exp_lo = 8'h00;
    logic [9:0]  value = 10'h000, approx;
    logic [1:0]  pos_ref;
    int          fail_count = 0, total_checks = 0, starts = 0, waits = 0, irqs = 0;
    int          ends = 0, dummy, s0, w0, i0, v;

    initial forever #25 core_clk_in = ~core_clk_in;

    adc_trigger_window_result_ctrl DUT (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .conversion_run_in(run), .comparator_power_on_in(pwr),
        .sw_start_in(sw_start), .stop_mode_in(stop), .timer_ch1_irq_in(trg[0]),
        .event_link_unit_in(trg[1]), .rtc_irq_in(trg[2]), .interval_timer_irq_in(trg[3]),
        .conv_end_in(conv_end), .approximation_reg_in(approx), .rdata_out(rdata),
        .conv_start_out(start), .power_wait_out(pwait), .stop_wake_convert_out(wake),
        .resolution_8bit_out(res8), .pos_ref_sel_out(pos_ref), .neg_ref_ext_out(neg_ref),
        .conversion_done_irq_out(irq));

    adc_core_model core_model (
        .core_clk_in(core_clk_in), .start_in(start), .delay_in(delay), .value_in(value),
        .end_out(conv_end), .approx_out(approx));

    always @(posedge core_clk_in) begin
        if (start === 1'b1) starts++;
        if (pwait === 1'b1) waits++;
        if (irq === 1'b1) irqs++;
        if (conv_end === 1'b1) ends++;
    end

    task automatic summarize();
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #2;
    endtask

    task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
        @(posedge core_clk_in); #2 wr = 1'b1; addr = a; wdata = d;
        @(posedge core_clk_in); #2 wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [19:0] a, input logic [7:0] e);
        @(posedge core_clk_in); #2 rd = 1'b1; addr = a;
        @(posedge core_clk_in); #2 rd = 1'b0;
        check({8'h00, rdata}, {8'h00, e}, "read");
    endtask

    // config written only while stopped and powered down
    task automatic cfg(input logic [7:0] tm, input logic [7:0] rw, input logic go);
        run = 1'b0; pwr = 1'b0;
        wr_reg(`ADR_TRIG_MODE, tm);
        wr_reg(`ADR_REF_WIN, rw);
        if (rw[7:6] == 2'b10) tick(100);
        pwr = 1'b1;
        tick(20);
        run = go;
    endtask

    task automatic pulse(input int i);
        @(posedge core_clk_in); #2 trg[i] = 1'b1;
        @(posedge core_clk_in); #2 trg = 4'h0;
    endtask

    function automatic logic passes(input logic [9:0] x, input logic inv);
        return inv ^ (x[9:2] >= lo && x[9:2] <= up);
    endfunction

    task automatic conv(input logic [9:0] x, input logic inv, input logic r8);
        int k, e0, n0;
        logic p;
        p = passes(x, inv);
        value = x; delay = 4'($urandom_range(0, 8)); n0 = irqs; e0 = ends;
        @(posedge core_clk_in); #2 sw_start = 1'b1;
        @(posedge core_clk_in); #2 sw_start = 1'b0;
        for (k = 0; k < 60 && ends == e0; k++) tick(1);
        if (ends == e0) begin
            fail_count++;
            $display("mismatch %0t conversion never ended", $time);
            summarize();
        end
        tick(2);
        check(16'(irqs - n0), {15'h0000, p}, "irq count");
        if (p) begin
            exp_hi = x[9:2];
            exp_lo = r8 ? 8'h00 : {x[1:0], 6'h00};
        end
        rd_chk(`ADR_RESULT_HI, exp_hi);
        rd_chk(`ADR_RESULT_LO, exp_lo);
    endtask

    initial begin
        dummy = $urandom(21);
        tick(5);
        rst_in = 1'b0;
        rd_chk(`ADR_REF_WIN, 8'h00);
        rd_chk(`ADR_UPPER_LIMIT, 8'hff);
        rd_chk(`ADR_LOWER_LIMIT, 8'h00);
        rd_chk(`ADR_TRIG_MODE, 8'h00);
        rd_chk(`ADR_RESULT_LO, 8'h00);
        rd_chk(`ADR_RESULT_HI, 8'h00);
        rd_chk(20'hf0013, 8'h00);
        wr_reg(`ADR_TRIG_MODE, 8'hff);
        rd_chk(`ADR_TRIG_MODE, 8'he3);
        wr_reg(`ADR_REF_WIN, 8'h7f);
        rd_chk(`ADR_REF_WIN, 8'h6d);
        check({13'h0000, pos_ref, neg_ref}, 16'h0003, "ref pins");
        check({15'h0000, res8}, 16'h0001, "resolution");
        for (int p = 0; p < 3; p++) begin
            wr_reg(`ADR_REF_WIN, 8'(p << 6));
            check({13'h0000, pos_ref, neg_ref}, 16'(p << 1), "plus ref");
        end
        lo = 8'($urandom_range(1, 120));
        up = 8'($urandom_range(lo + 1, 254));
        wr_reg(`ADR_UPPER_LIMIT, up);
        wr_reg(`ADR_LOWER_LIMIT, lo);
        for (int m = 0; m < 4; m++) begin
            cfg(m[0] ? 8'h60 : 8'h20, {4'h0, m[1], 2'h0, m[0]}, 1'b1);
            conv({lo, 2'h0}, m[1], m[0]);
            conv({up, 2'h3}, m[1], m[0]);
            conv({lo - 8'h01, 2'h3}, m[1], m[0]);
            conv({up + 8'h01, 2'h0}, m[1], m[0]);
            repeat (3) conv(10'($urandom), m[1], m[0]);
        end
        value = {lo, 2'h1};
        cfg(8'h00, 8'h00, 1'b1);
        s0 = starts;
        @(posedge core_clk_in); #2 sw_start = 1'b1;
        @(posedge core_clk_in); #2 sw_start = 1'b0;
        tick(40);
        check(16'(starts - s0 >= 3), 16'h0001, "sequential restart");
        for (int s = 0; s < 4; s++) begin
            cfg(8'ha0 | 8'(s), 8'h00, 1'b1);
            s0 = starts; w0 = waits;
            pulse(s);
            tick(15);
            check(16'(starts - s0), 16'h0001, "hw start");
            check(16'(waits - w0), 16'h0000, "no wait");
            pulse(s ^ 1);
            tick(15);
            check(16'(starts - s0), 16'h0001, "other source");
            cfg(8'he0 | 8'(s), 8'h00, 1'b1);
            w0 = waits;
            pulse(s);
            tick(15);
            check(16'(waits - w0), 16'h0001, "wait mode");
        end
        cfg(8'he0, 8'h04, 1'b0);
        stop = 1'b1;
        tick(2);
        check({15'h0000, wake}, 16'h0001, "wake level");
        s0 = starts; i0 = irqs;
        pulse(0);
        tick(15);
        check(16'(starts - s0), 16'h0001, "stop start");
        check(16'(irqs - i0), 16'h0001, "stop irq");
        stop = 1'b0;
        cfg(8'h20, 8'h00, 1'b0);
        check({15'h0000, wake}, 16'h0000, "wake cleared");
        summarize();
    end
endmodule
